// *** logic/crs_pkg.sv ***
package crs_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam int GPR_N  = 13;
  localparam int IDX_W  = 4;
  localparam int PRIO_W = 9;
  localparam int APP_W  = 5;
  localparam int INUM_W = 9;
  localparam int ELO_W  = 6;
  localparam int EHI_W  = 2;
  localparam int MODE_W = 2;

  localparam logic [IDX_W-1:0] IDX_LOW_LAST = 4'h7;
  localparam logic [IDX_W-1:0] IDX_SP       = 4'hd;
  localparam logic [IDX_W-1:0] IDX_LR       = 4'he;
  localparam logic [IDX_W-1:0] IDX_PC       = 4'hf;

  localparam logic [ADDR_W-1:0] OFS_GPR0     = 7'h00;
  localparam logic [ADDR_W-1:0] OFS_SP       = 7'h34;
  localparam logic [ADDR_W-1:0] OFS_LR       = 7'h38;
  localparam logic [ADDR_W-1:0] OFS_PC       = 7'h3c;
  localparam logic [ADDR_W-1:0] OFS_STAT_ALL = 7'h40;
  localparam logic [ADDR_W-1:0] OFS_APP      = 7'h44;
  localparam logic [ADDR_W-1:0] OFS_INUM     = 7'h48;
  localparam logic [ADDR_W-1:0] OFS_EXEC     = 7'h4c;
  localparam logic [ADDR_W-1:0] OFS_PRIM     = 7'h50;
  localparam logic [ADDR_W-1:0] OFS_FMASK    = 7'h54;
  localparam logic [ADDR_W-1:0] OFS_BPRI     = 7'h58;
  localparam logic [ADDR_W-1:0] OFS_MODE     = 7'h5c;
  localparam logic [ADDR_W-1:0] OFS_MAIN_SP  = 7'h60;
  localparam logic [ADDR_W-1:0] OFS_PROC_SP  = 7'h64;
  localparam logic [ADDR_W-1:0] OFS_FAULT    = 7'h68;

  localparam int APP_LSB  = 27;
  localparam int EHI_LSB  = 25;
  localparam int ISET_BIT = 24;
  localparam int ELO_LSB  = 10;
  localparam int MODE_USER_BIT = 0;
  localparam int MODE_PSP_BIT  = 1;
  localparam int FLT_ISET_BIT  = 0;
  localparam int FLT_PRIV_BIT  = 1;
  localparam int FLT_HNDL_BIT  = 8;
  localparam int FLT_USER_BIT  = 9;

  localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SP_ALIGN = 32'hffff_fffc;
  localparam logic [DATA_W-1:0] PC_ALIGN = 32'hffff_fffe;
  localparam logic [APP_W-1:0]  APP_RST  = 5'h00;
  localparam logic [INUM_W-1:0] INUM_RST = 9'h000;
  localparam logic [ELO_W-1:0]  ELO_RST  = 6'h00;
  localparam logic [EHI_W-1:0]  EHI_RST  = 2'h0;
  localparam logic [PRIO_W-1:0] BPRI_RST = 9'h000;
  localparam logic [MODE_W-1:0] MODE_RST = 2'h0;
  localparam logic              MASK_RST = 1'b0;
  localparam logic [1:0]        FLT_RST  = 2'h0;
  localparam logic              ISET_ONE = 1'b1;

  typedef enum logic [1:0] {
    KIND_NMI   = 2'h0,
    KIND_HARD  = 2'h1,
    KIND_OTHER = 2'h3
  } crs_kind_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } crs_bus_t;
endpackage

// *** logic/crs_gpr_bank.sv ***
`timescale 1ns/1ps
module crs_gpr_bank (
  input  wire logic                         mclk,
  input  wire logic                         reset_n,
  input  wire logic                         clk_en,
  input  wire logic                         wr_en,
  input  wire logic [crs_pkg::IDX_W-1:0]    wr_idx,
  input  wire logic [crs_pkg::DATA_W-1:0]   wr_data,
  input  wire logic [crs_pkg::IDX_W-1:0]    rd_a_idx,
  output logic      [crs_pkg::DATA_W-1:0]   rd_a_data,
  input  wire logic [crs_pkg::IDX_W-1:0]    rd_b_idx,
  output logic      [crs_pkg::DATA_W-1:0]   rd_b_data
);
  import crs_pkg::*;

  logic [DATA_W-1:0] gpr_reg [GPR_N];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int i = 0; i < GPR_N; i++) begin
        gpr_reg[i] <= WORD_RST;
      end
    end else if (clk_en && wr_en && (int'(wr_idx) < GPR_N)) begin
      gpr_reg[wr_idx] <= wr_data;
    end
  end

  // Indices past the bank read zero so callers need no range check.
  assign rd_a_data = (int'(rd_a_idx) < GPR_N) ? gpr_reg[rd_a_idx] : WORD_RST;
  assign rd_b_data = (int'(rd_b_idx) < GPR_N) ? gpr_reg[rd_b_idx] : WORD_RST;
endmodule

// *** logic/crs_mask_eval.sv ***
`timescale 1ns/1ps
module crs_mask_eval (
  input  wire logic                       prim_mask,
  input  wire logic                       fault_mask,
  input  wire logic [crs_pkg::PRIO_W-1:0] base_prio,
  input  crs_pkg::crs_kind_t              cand_kind,
  input  wire logic [crs_pkg::PRIO_W-1:0] cand_prio,
  output logic                            permit
);
  import crs_pkg::*;

  logic prio_ok;

  // A zero threshold turns priority masking off altogether.
  assign prio_ok = (base_prio == BPRI_RST) || (cand_prio < base_prio);

  always_comb begin
    case (cand_kind)
      KIND_NMI:   permit = 1'b1;
      KIND_HARD:  permit = !fault_mask;
      KIND_OTHER: permit = !fault_mask && !prim_mask && prio_ok;
      default:    permit = 1'b0;
    endcase
  end
endmodule

// *** logic/crs_top.sv ***
// What this block does
// - All sixteen core registers are full 32-bit storage.
// - Low general registers 0-7 are reachable by every access, any length.
// - High general registers 8-12 are unreachable from narrow 16-bit accesses.
// - Stack pointer banks main and process copies; process only in thread operation.
// - Stack pointer low two bits always read and store as zero.
// - A subroutine call loads its return address into the link register.
// - Instruction pointer bit zero always reads and stores as zero.
// - Status word readable combined or as three separate views; all but the exception number are writable.
// - Application flags sit in status bits 31 down to 27.
// - Active exception number sits in the nine lowest interrupt status bits.
// - Execution state fields live at bits 15:10 and 26:25.
// - Execution bit 24 stays one; a clearing write raises a fault.
// - Primary mask set lets through only non-maskable interrupt and hard fault.
// - Fault mask set lets through only the non-maskable interrupt.
// - Nonzero base priority blocks candidates with equal or higher priority value.
// - Base priority of zero disables priority masking.
// - Mode bit zero selects privileged or user thread operation.
// - Mode bit one selects main or process stack in thread operation.
// - Stack-select bit holds zero throughout handler mode.
// - Handler mode while servicing an exception, always privileged; thread otherwise.
// - User level access to protected special registers is refused with a fault.
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module crs_top (
  input  wire logic                         mclk,
  input  wire logic                         reset_n,
  input  wire logic                         clk_en,
  input  wire logic [crs_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [crs_pkg::DATA_W-1:0]   avs_writedata,
  output logic      [crs_pkg::DATA_W-1:0]   avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic                         core_wr_en,
  input  wire logic [crs_pkg::IDX_W-1:0]    core_wr_idx,
  input  wire logic [crs_pkg::DATA_W-1:0]   core_wr_data,
  input  wire logic                         core_narrow,
  input  wire logic [crs_pkg::IDX_W-1:0]    core_rd_idx,
  output logic      [crs_pkg::DATA_W-1:0]   core_rd_data,
  input  wire logic                         call_en,
  input  wire logic [crs_pkg::DATA_W-1:0]   call_ret_addr,
  input  wire logic                         flags_wr_en,
  input  wire logic [crs_pkg::APP_W-1:0]    flags_in,
  input  wire logic                         exc_enter,
  input  wire logic [crs_pkg::INUM_W-1:0]   exc_number,
  input  wire logic                         exc_return,
  input  wire logic                         exc_ret_psp,
  input  crs_pkg::crs_kind_t                cand_kind,
  input  wire logic [crs_pkg::PRIO_W-1:0]   cand_prio,
  output logic                              cand_permit,
  output logic                              handler_mode,
  output logic                              user_level,
  output logic                              psp_active,
  output logic                              fault_pulse
);
  import crs_pkg::*;

  logic [DATA_W-1:0] msp_reg;
  logic [DATA_W-1:0] psp_reg;
  logic [DATA_W-1:0] link_reg;
  logic [DATA_W-1:0] pc_reg;
  logic [APP_W-1:0]  app_reg;
  logic [INUM_W-1:0] inum_reg;
  logic [ELO_W-1:0]  elo_reg;
  logic [EHI_W-1:0]  ehi_reg;
  logic              prim_reg;
  logic              fmask_reg;
  logic [PRIO_W-1:0] bpri_reg;
  logic [MODE_W-1:0] mode_reg;
  logic              handler_reg;
  logic [1:0]        flt_reg;
  logic [1:0]        flt_next;
  logic              fault_reg;
  crs_bus_t          st_reg;
  logic              busy_q_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] core_rd_reg;
  logic [DATA_W-1:0] gpr_a;
  logic [DATA_W-1:0] gpr_b;
  logic [DATA_W-1:0] stat_all;
  logic [DATA_W-1:0] sp_view;
  logic              core_busy;
  logic              bus_req;
  logic              bus_take;
  logic              refuse;
  logic              bw;
  logic              iset_clear;
  logic              core_gpr_ok;
  logic              bus_gpr_wr;
  logic              bank_wr;
  logic [IDX_W-1:0]  bank_idx;
  logic [DATA_W-1:0] bank_data;

  // Special registers that user level code may not touch.
  function automatic logic is_protected(input logic [ADDR_W-1:0] a);
    return (a == OFS_STAT_ALL) || (a == OFS_EXEC) || (a == OFS_PRIM) ||
           (a == OFS_FMASK) || (a == OFS_BPRI) || (a == OFS_MODE) ||
           (a == OFS_MAIN_SP) || (a == OFS_PROC_SP);
  endfunction

  function automatic logic high_gpr(input logic [IDX_W-1:0] idx);
    return (idx > IDX_LOW_LAST) && (int'(idx) < GPR_N);
  endfunction

  assign handler_mode = handler_reg;
  assign user_level   = !handler_reg && mode_reg[MODE_USER_BIT];
  assign psp_active   = !handler_reg && mode_reg[MODE_PSP_BIT];
  assign sp_view      = psp_active ? psp_reg : msp_reg;
  assign fault_pulse  = fault_reg;

  // One combined view assembled from the three separate fields.
  assign stat_all = {app_reg, ehi_reg, ISET_ONE, 8'h00, elo_reg, 1'b0, inum_reg};

  function automatic logic [DATA_W-1:0] bus_view(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = WORD_RST;
    if (a < OFS_SP) begin
      v = gpr_a;
    end else begin
      case (a)
        OFS_SP:       v = sp_view;
        OFS_LR:       v = link_reg;
        OFS_PC:       v = pc_reg;
        OFS_STAT_ALL: v = stat_all;
        OFS_APP:      v = {app_reg, 27'h0000000};
        OFS_INUM:     v = {23'h000000, inum_reg};
        OFS_EXEC:     v = {5'h00, ehi_reg, ISET_ONE, 8'h00, elo_reg, 10'h000};
        OFS_PRIM:     v = {31'h00000000, prim_reg};
        OFS_FMASK:    v = {31'h00000000, fmask_reg};
        OFS_BPRI:     v = {23'h000000, bpri_reg};
        OFS_MODE:     v = {30'h00000000, mode_reg};
        OFS_MAIN_SP:  v = msp_reg;
        OFS_PROC_SP:  v = psp_reg;
        OFS_FAULT:    v = {22'h000000, user_level, handler_reg, 6'h00, flt_reg};
        default:      v = WORD_RST;
      endcase
    end
    return v;
  endfunction

  function automatic logic [DATA_W-1:0] core_view(input logic [IDX_W-1:0] idx);
    logic [DATA_W-1:0] v;
    v = gpr_b;
    if (core_narrow && high_gpr(idx)) begin
      v = WORD_RST;
    end else if (idx == IDX_SP) begin
      v = sp_view;
    end else if (idx == IDX_LR) begin
      v = link_reg;
    end else if (idx == IDX_PC) begin
      v = pc_reg;
    end
    return v;
  endfunction

  // Core traffic always wins; the bus waits until the core has been quiet
  // for a cycle so that captured read data is never stale.
  assign core_busy = core_wr_en || call_en || flags_wr_en || exc_enter || exc_return;
  assign bus_req   = avs_read || avs_write;
  assign bus_take  = clk_en && bus_req && (st_reg == BUS_ACK) && !core_busy && !busy_q_reg;
  assign avs_waitrequest = !bus_take;
  assign avs_readdata    = rdata_reg;
  assign core_rd_data    = core_rd_reg;

  assign refuse = user_level && is_protected(avs_address);
  assign bw     = bus_take && avs_write && !refuse;
  assign iset_clear = bw && !avs_writedata[ISET_BIT] &&
                      ((avs_address == OFS_STAT_ALL) || (avs_address == OFS_EXEC));

  assign core_gpr_ok = core_wr_en && !(core_narrow && high_gpr(core_wr_idx));
  assign bus_gpr_wr  = bw && (avs_address < OFS_SP);
  assign bank_wr     = (core_gpr_ok && (int'(core_wr_idx) < GPR_N)) || bus_gpr_wr;
  assign bank_idx    = core_wr_en ? core_wr_idx : avs_address[5:2];
  assign bank_data   = core_wr_en ? core_wr_data : avs_writedata;

  crs_gpr_bank u_gpr (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .wr_en     (bank_wr),
    .wr_idx    (bank_idx),
    .wr_data   (bank_data),
    .rd_a_idx  (avs_address[5:2]),
    .rd_a_data (gpr_a),
    .rd_b_idx  (core_rd_idx),
    .rd_b_data (gpr_b)
  );

  crs_mask_eval u_mask (
    .prim_mask  (prim_reg),
    .fault_mask (fmask_reg),
    .base_prio  (bpri_reg),
    .cand_kind  (cand_kind),
    .cand_prio  (cand_prio),
    .permit     (cand_permit)
  );

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_reg     <= BUS_IDLE;
      busy_q_reg <= 1'b0;
      rdata_reg  <= WORD_RST;
    end else if (clk_en) begin
      busy_q_reg <= core_busy;
      if (bus_req) begin
        rdata_reg <= refuse ? WORD_RST : bus_view(avs_address);
      end
      case (st_reg)
        BUS_IDLE: if (bus_req) st_reg <= BUS_ACK;
        BUS_ACK:  if (bus_take) st_reg <= BUS_IDLE;
        default:  st_reg <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      core_rd_reg <= WORD_RST;
    end else if (clk_en) begin
      core_rd_reg <= core_view(core_rd_idx);
    end
  end

  // Stack pointers, link and instruction pointer; alignment is forced on stack and instruction pointer stores.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      msp_reg  <= WORD_RST;
      psp_reg  <= WORD_RST;
      link_reg <= WORD_RST;
      pc_reg   <= WORD_RST;
    end else if (clk_en) begin
      if (call_en) begin
        link_reg <= call_ret_addr;
      end else if (core_wr_en && core_wr_idx == IDX_LR) begin
        link_reg <= core_wr_data;
      end else if (bw && avs_address == OFS_LR) begin
        link_reg <= avs_writedata;
      end
      if (core_wr_en && core_wr_idx == IDX_PC) begin
        pc_reg <= core_wr_data & PC_ALIGN;
      end else if (bw && avs_address == OFS_PC) begin
        pc_reg <= avs_writedata & PC_ALIGN;
      end
      if ((core_wr_en && core_wr_idx == IDX_SP && !psp_active) ||
          (bw && avs_address == OFS_SP && !psp_active && !core_busy) ||
          (bw && avs_address == OFS_MAIN_SP)) begin
        msp_reg <= (core_wr_en ? core_wr_data : avs_writedata) & SP_ALIGN;
      end
      if ((core_wr_en && core_wr_idx == IDX_SP && psp_active) ||
          (bw && avs_address == OFS_SP && psp_active) ||
          (bw && avs_address == OFS_PROC_SP)) begin
        psp_reg <= (core_wr_en ? core_wr_data : avs_writedata) & SP_ALIGN;
      end
    end
  end

  // Status fields. Bit 24 has no storage; it reads as one in the combined and execution views unless a user level read is refused.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      app_reg  <= APP_RST;
      elo_reg  <= ELO_RST;
      ehi_reg  <= EHI_RST;
      inum_reg <= INUM_RST;
    end else if (clk_en) begin
      if (flags_wr_en) begin
        app_reg <= flags_in;
      end else if (bw && (avs_address == OFS_STAT_ALL || avs_address == OFS_APP)) begin
        app_reg <= avs_writedata[APP_LSB +: APP_W];
      end
      if (bw && (avs_address == OFS_STAT_ALL || avs_address == OFS_EXEC)) begin
        elo_reg <= avs_writedata[ELO_LSB +: ELO_W];
        ehi_reg <= avs_writedata[EHI_LSB +: EHI_W];
      end
      if (exc_enter) begin
        inum_reg <= exc_number;
      end else if (exc_return) begin
        inum_reg <= INUM_RST;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prim_reg    <= MASK_RST;
      fmask_reg   <= MASK_RST;
      bpri_reg    <= BPRI_RST;
      mode_reg    <= MODE_RST;
      handler_reg <= 1'b0;
    end else if (clk_en) begin
      if (bw && avs_address == OFS_PRIM) prim_reg <= avs_writedata[0];
      if (bw && avs_address == OFS_FMASK) fmask_reg <= avs_writedata[0];
      if (bw && avs_address == OFS_BPRI) bpri_reg <= avs_writedata[PRIO_W-1:0];
      if (exc_enter) begin
        handler_reg <= 1'b1;
        mode_reg[MODE_PSP_BIT] <= 1'b0;
      end else if (exc_return) begin
        handler_reg <= 1'b0;
        mode_reg[MODE_PSP_BIT] <= exc_ret_psp;
      end else if (bw && avs_address == OFS_MODE) begin
        mode_reg[MODE_USER_BIT] <= avs_writedata[MODE_USER_BIT];
        mode_reg[MODE_PSP_BIT]  <= avs_writedata[MODE_PSP_BIT] && !handler_reg;
      end
    end
  end

  // Fault causes are sticky and clear by writing one; a new fault wins.
  always_comb begin
    flt_next = flt_reg;
    if (bw && avs_address == OFS_FAULT) begin
      flt_next = flt_reg & ~avs_writedata[1:0];
    end
    if (iset_clear) flt_next[FLT_ISET_BIT] = 1'b1;
    if (bus_take && refuse) flt_next[FLT_PRIV_BIT] = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      flt_reg   <= FLT_RST;
      fault_reg <= 1'b0;
    end else if (clk_en) begin
      flt_reg   <= flt_next;
      fault_reg <= iset_clear || (bus_take && refuse);
    end
  end

  a_sp_aligned: assert property (@(posedge mclk) disable iff (!reset_n)
    (msp_reg[1:0] == 2'h0) && (psp_reg[1:0] == 2'h0))
    else $error("stack pointer lost word alignment");

  a_pc_aligned: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && core_wr_en && core_wr_idx == IDX_PC |=> pc_reg == ($past(core_wr_data) & PC_ALIGN))
    else $error("instruction pointer write not stored half-word aligned");

  a_call_link: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && call_en |=> link_reg == $past(call_ret_addr))
    else $error("call did not load the return address");

  a_iset_fault: assert property (@(posedge mclk) disable iff (!reset_n)
    iset_clear |=> fault_pulse && flt_reg[FLT_ISET_BIT] && stat_all[ISET_BIT])
    else $error("clearing the execution state bit did not fault");

  a_user_refuse: assert property (@(posedge mclk) disable iff (!reset_n)
    bus_take && avs_write && user_level && avs_address == OFS_PRIM
    |=> fault_pulse && prim_reg == $past(prim_reg))
    else $error("user level write to a protected register was not refused");

  a_handler_stack: assert property (@(posedge mclk) disable iff (!reset_n)
    handler_reg |-> !mode_reg[MODE_PSP_BIT] && !psp_active && !user_level)
    else $error("handler mode with process stack or user level");

  a_enter_number: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && exc_enter |=> handler_mode && stat_all[INUM_W-1:0] == $past(exc_number))
    else $error("exception entry not recorded");

  a_prim_block: assert property (@(posedge mclk) disable iff (!reset_n)
    prim_reg && cand_kind == KIND_OTHER |-> !cand_permit)
    else $error("primary mask let an ordinary exception through");

  a_fault_block: assert property (@(posedge mclk) disable iff (!reset_n)
    fmask_reg |-> cand_permit == (cand_kind == KIND_NMI))
    else $error("fault mask admitted something other than the non-maskable interrupt");

  a_bpri_level: assert property (@(posedge mclk) disable iff (!reset_n)
    bpri_reg != BPRI_RST && cand_kind == KIND_OTHER && cand_prio >= bpri_reg |-> !cand_permit)
    else $error("base priority failed to block");

  a_bpri_off: assert property (@(posedge mclk) disable iff (!reset_n)
    bpri_reg == BPRI_RST && !prim_reg && !fmask_reg && cand_kind == KIND_OTHER |-> cand_permit)
    else $error("zero base priority still masked");

  a_reset_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(reset_n) |-> !prim_reg && !fmask_reg && bpri_reg == BPRI_RST && mode_reg == MODE_RST)
    else $error("masks or mode not cleared by reset");
endmodule

// *** verification/crs_core_model.sv ***
`timescale 1ns/1ps
module crs_core_model (
  input  wire logic mclk,
  output logic core_wr_en,
  output logic [3:0] core_wr_idx,
  output logic [31:0] core_wr_data,
  output logic call_en,
  output logic [31:0] call_ret_addr,
  output logic exc_enter,
  output logic [8:0] exc_number,
  output logic exc_return,
  output logic exc_ret_psp
);
  initial begin
    {core_wr_en, call_en, exc_enter, exc_return} = '0;
    {core_wr_idx, core_wr_data, call_ret_addr, exc_number, exc_ret_psp} = '0;
  end
  // Write and return data are inverted after a strobe, so stale data never looks valid.
  task automatic act(input logic [1:0] k, input logic [3:0] i, input logic [31:0] d);
    core_wr_idx <= i;
    core_wr_data <= d;
    call_ret_addr <= d;
    exc_number <= d[8:0];
    exc_ret_psp <= d[0];
    core_wr_en <= (k == 2'h0);
    call_en <= (k == 2'h1);
    exc_enter <= (k == 2'h2);
    exc_return <= (k == 2'h3);
    @(posedge mclk);
    {core_wr_en, call_en, exc_enter, exc_return} <= '0;
    core_wr_data <= ~d;
    call_ret_addr <= ~d;
    // An idle edge keeps a following call from re-raising a strobe in the same step.
    @(posedge mclk);
  endtask
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import crs_pkg::*;
  logic mclk, reset_n, clk_en, avs_read, avs_write, avs_waitrequest, core_narrow;
  logic flags_wr_en, cand_permit, handler_mode, user_level, psp_active, fault_pulse;
  logic core_wr_en, call_en, exc_enter, exc_return, exc_ret_psp, hung, p, fm;
  logic [6:0] avs_address;
  logic [3:0] core_wr_idx, core_rd_idx;
  logic [4:0] flags_in;
  logic [8:0] exc_number, cand_prio, b, q;
  logic [31:0] avs_writedata, avs_readdata, core_wr_data, core_rd_data, call_ret_addr;
  logic [31:0] r, d, v[16];
  crs_kind_t cand_kind;
  int miscompares, check_count, faults, f0;
  integer seed = 75;
  crs_top crs_top_i (.mclk, .reset_n, .clk_en, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .core_wr_en, .core_wr_idx,
    .core_wr_data, .core_narrow, .core_rd_idx, .core_rd_data, .call_en, .call_ret_addr,
    .flags_wr_en, .flags_in, .exc_enter, .exc_number, .exc_return, .exc_ret_psp,
    .cand_kind, .cand_prio, .cand_permit, .handler_mode, .user_level, .psp_active,
    .fault_pulse);
  crs_core_model crs_core_model_i (.mclk, .core_wr_en, .core_wr_idx, .core_wr_data,
    .call_en, .call_ret_addr, .exc_enter, .exc_number, .exc_return, .exc_ret_psp);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (fault_pulse === 1'b1)
      faults <= faults + 1;
  always @(posedge mclk)
    if (hung)
      finish_test();
  function automatic logic [31:0] reg_exp(input int i, input logic n, input logic [31:0] x);
    if (n && i >= 8 && i <= 12)
      return 32'h0;
    if (i == 13)
      return x & SP_ALIGN;
    return (i == 15) ? (x & PC_ALIGN) : x;
  endfunction
  function automatic logic perm_exp(input int k);
    if (k == 2)
      return 1'b0;
    if (k == 0)
      return 1'b1;
    if (fm)
      return 1'b0;
    return (k == 1) || (!p && (b == 9'h0 || q < b));
  endfunction
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // The request is held until waitrequest is seen low; a hang ends the run.
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] x);
    avs_address <= a;
    avs_writedata <= x;
    avs_write <= w;
    avs_read <= !w;
    for (int n = 0; n <= 60; n++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0)
        break;
      if (n == 60) begin
        miscompares++;
        hung = 1'b1;
      end
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // One idle edge lets the write land and keeps strobes from toggling twice in one step.
    @(posedge mclk);
  endtask
  task automatic rdc(input string s, input logic [6:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(s, e, r);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {reset_n, avs_read, avs_write, core_narrow, flags_wr_en, hung} = '0;
    {avs_address, avs_writedata, core_rd_idx, flags_in, cand_prio} = '0;
    clk_en = 1'b1;
    cand_kind = KIND_OTHER;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int a = 'h50; a <= 'h5c; a += 4)
      rdc("mask reset", 7'(a), 32'h0);
    for (int i = 0; i < 16; i++) begin
      v[i] = $random(seed);
      crs_core_model_i.act(2'h0, 4'(i), v[i]);
    end
    for (int i = 0; i < 16; i++) begin
      core_rd_idx <= 4'(i);
      core_narrow <= i[0];
      repeat (2) @(posedge mclk);
      chk("core read", reg_exp(i, i[0], v[i]), core_rd_data);
      rdc("bus read", 7'(4 * i), reg_exp(i, 1'b0, v[i]));
    end
    d = $random(seed);
    crs_core_model_i.act(2'h1, 4'h0, d);
    rdc("link", OFS_LR, d);
    clk_en <= 1'b0;
    crs_core_model_i.act(2'h1, 4'h0, ~d);
    clk_en <= 1'b1;
    rdc("frozen link", OFS_LR, d);
    flags_in <= 5'($random(seed));
    flags_wr_en <= 1'b1;
    @(posedge mclk);
    flags_wr_en <= 1'b0;
    rdc("flags", OFS_STAT_ALL, {flags_in, 27'h0} | 32'h0100_0000);
    d = ($random(seed) & 32'hfe00_fc00) | 32'h0100_0000;
    bus(1'b1, OFS_STAT_ALL, d);
    rdc("status", OFS_STAT_ALL, d);
    v[0] = ($random(seed) & 32'h0600_fc00) | 32'h0100_0000;
    bus(1'b1, OFS_EXEC, v[0]);
    rdc("exec view", OFS_STAT_ALL, (d & 32'hf800_0000) | v[0]);
    f0 = faults;
    bus(1'b1, OFS_STAT_ALL, 32'h0);
    rdc("bit24", OFS_STAT_ALL, 32'h0100_0000);
    rdc("fault bit", OFS_FAULT, 32'h1);
    chk("fault count", f0 + 1, faults);
    bus(1'b1, OFS_FAULT, 32'h3);
    for (int t = 0; t < 12; t++) begin
      {p, fm} = 2'($random(seed));
      b = (t < 3) ? 9'h0 : 9'($random(seed));
      bus(1'b1, OFS_PRIM, {31'h0, p});
      bus(1'b1, OFS_FMASK, {31'h0, fm});
      bus(1'b1, OFS_BPRI, {23'h0, b});
      for (int k = 0; k < 4; k++) begin
        q = t[0] ? b : 9'($random(seed));
        cand_kind <= crs_kind_t'(k);
        cand_prio <= q;
        @(posedge mclk);
        chk("permit", {31'h0, perm_exp(k)}, {31'h0, cand_permit});
      end
    end
    bus(1'b1, OFS_MODE, 32'h2);
    d = $random(seed);
    crs_core_model_i.act(2'h0, IDX_SP, d);
    rdc("proc sp", OFS_PROC_SP, d & SP_ALIGN);
    rdc("main sp", OFS_MAIN_SP, v[13] & SP_ALIGN);
    q = 9'($random(seed)) | 9'h1;
    crs_core_model_i.act(2'h2, 4'h0, {23'h0, q});
    @(posedge mclk);
    chk("modes", 32'h2, {30'h0, handler_mode, psp_active});
    rdc("number", OFS_INUM, {23'h0, q});
    rdc("stack bit", OFS_MODE, 32'h0);
    crs_core_model_i.act(2'h3, 4'h0, 32'h1);
    bus(1'b1, OFS_MODE, 32'h3);
    chk("user modes", 32'h3, {30'h0, user_level, psp_active});
    f0 = faults;
    rdc("refused", OFS_MAIN_SP, 32'h0);
    bus(1'b1, OFS_PRIM, 32'h1);
    rdc("fault user", OFS_FAULT, 32'h202);
    chk("refusals", f0 + 2, faults);
    finish_test();
  end
endmodule
